// ---- qrd_pkg.sv ----
// Shared constants for the quad I/O continuous read link.
// Assumes both ends include this package and reference it by scope.
`default_nettype none
package qrd_pkg;
   // ==========================================================
   // Opcodes and mode byte
   localparam logic [7:0] QUAD_IO_FAST_READ              = 8'hEB;
   localparam logic [7:0] QUAD_IO_FAST_READ_WIDE_ADDRESS = 8'hEC;
   localparam logic [3:0] SKIP_KEY_NIBBLE                = 4'hA;
   // ==========================================================
   // Phase lengths in link clocks
   localparam int OPCODE_CLOCKS    = 8;
   localparam int MODE_CLOCKS      = 2;
   localparam int ADDR3_CLOCKS     = 6;
   localparam int ADDR4_CLOCKS     = 8;
   localparam int DUMMY_DEFAULT    = 6;
   localparam int DUMMY_W          = 5;
   // ==========================================================
   // Reset values
   localparam logic RST_SKIP_MODE  = 1'b0;
   localparam logic [3:0] RST_NIB  = 4'h0;
   localparam logic [3:0] IO_OE_OFF = 4'hF;  // Output enables are active low
endpackage
`default_nettype wire

// ---- qrd_if.sv ----
// Link wires between the host controller and the flash read logic.
// Resolves the shared IO lines here from both enables, host first.
`timescale 1ns/1ps
`default_nettype none
interface qrd_if;
   logic       sclk;       // Link clock, made by host
   logic       cs_b;       // Chip select, active low
   logic [3:0] h_io_o;     // Host drive value
   logic [3:0] h_io_oe_b;  // Host enable, low drives
   logic [3:0] d_io_o;     // Device drive value
   logic [3:0] d_io_oe_b;  // Device enable, low drives
   logic [3:0] io;         // Resolved line level

   // Weak pull-up where nobody drives
   genvar g;
   for (g = 0; g < 4; g++)
   begin : g_res
      assign io[g] = !h_io_oe_b[g] ? h_io_o[g] : (!d_io_oe_b[g] ? d_io_o[g] : 1'b1);
   end

   modport host (output sclk, output cs_b, output h_io_o, output h_io_oe_b, input io);
   modport dev  (input sclk, input cs_b, output d_io_o, output d_io_oe_b, input io);
endinterface
`default_nettype wire

// ---- qrd_host.sv ----
// Host end: issues quad I/O reads and receives nibbles.
// Assumes a single-cycle start pulse and a reader always ready for data.
`timescale 1ns/1ps
`default_nettype none
module qrd_host #(
   parameter int DUMMY_CLOCKS = qrd_pkg::DUMMY_DEFAULT
) (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        start_i,        // Begin one read
   input  wire logic [31:0] addr_i,
   input  wire logic        wide_i,         // Four address bytes
   input  wire logic        wide_op_i,      // Use the wide-address opcode
   input  wire logic        skip_op_i,      // Device is in opcode skip mode
   input  wire logic        stay_i,         // Ask to stay in skip mode
   input  wire logic [15:0] nibbles_i,      // Data nibbles to read
   output logic             busy_o,
   output logic             data_valid_o,
   output logic [7:0]       data_o,
   qrd_if.host              lnk
);
   typedef enum {H_IDLE, H_LOW, H_HIGH} hstate_e;
   typedef enum {P_OP, P_ADDR, P_MODE, P_DUMMY, P_DATA, P_END} phase_e;
   typedef struct packed {
      hstate_e    st;
      phase_e     ph;
      logic [7:0] cnt;
      logic [15:0] left;
      logic [39:0] sh;
      logic       sclk;
      logic       cs_b;
      logic [3:0] io;
      logic [3:0] oe_b;
      logic [3:0] hi;
      logic       half;
      logic [7:0] data;
      logic       dv;
   } hst_s;
   hst_s r, n;
   logic [7:0] op;

   // ==========================================================
   // Sequencer: sclk is ref clock divided by two
   always_comb
   begin
      n = r;
      n.dv = 1'b0;
      op = wide_op_i ? qrd_pkg::QUAD_IO_FAST_READ_WIDE_ADDRESS : qrd_pkg::QUAD_IO_FAST_READ;
      unique case (r.st)
         H_IDLE:
         begin
            n.sclk = 1'b0;
            if (start_i)
            begin
               n.st = H_LOW;
               n.cs_b = 1'b0;
               n.left = nibbles_i;
               n.half = 1'b0;
               n.sh = wide_i ? {addr_i, stay_i ? 8'hA0 : 8'h00} : {addr_i[23:0], stay_i ? 8'hA0 : 8'h00, 8'h00};
               if (skip_op_i)
               begin
                  n.ph = P_ADDR;
                  n.cnt = 8'(wide_i ? qrd_pkg::ADDR4_CLOCKS : qrd_pkg::ADDR3_CLOCKS);
                  n.io = n.sh[39:36];
                  n.oe_b = 4'h0;
               end
               else
               begin
                  n.ph = P_OP;
                  n.cnt = 8'(qrd_pkg::OPCODE_CLOCKS);
                  n.sh[7:0] = n.sh[7:0];
                  n.io = {3'b000, op[7]};
                  n.oe_b = 4'hE;
               end
            end
         end
         H_LOW:
         begin
            n.sclk = 1'b1;           // Device samples on this rising edge
            n.st = H_HIGH;
            if (r.ph == P_DATA)
            begin
               n.half = ~r.half;
               n.data = r.half ? {r.hi, lnk.io} : r.data;
               n.dv = r.half;
               n.hi = lnk.io;
            end
         end
         H_HIGH:
         begin
            n.sclk = 1'b0;
            n.st = H_LOW;
            n.cnt = r.cnt - 8'h01;
            if (r.ph == P_OP)
               n.io = {3'b000, op[3'(r.cnt - 8'h02)]};
            else if (r.ph == P_ADDR || r.ph == P_MODE)
            begin
               n.sh = {r.sh[35:0], 4'h0};
               n.io = r.sh[35:32];
            end
            if (r.ph == P_DATA)
            begin
               n.left = r.left - 16'h0001;
               if (r.left == 16'h0001)
               begin
                  n.st = H_IDLE;
                  n.cs_b = 1'b1;
                  n.ph = P_END;
               end
            end
            else if (r.cnt == 8'h01)
            begin
               unique case (r.ph)
                  P_OP:
                  begin
                     n.ph = P_ADDR;
                     n.cnt = 8'(wide_i ? qrd_pkg::ADDR4_CLOCKS : qrd_pkg::ADDR3_CLOCKS);
                     n.io = r.sh[39:36];
                     n.oe_b = 4'h0;
                  end
                  P_ADDR:
                  begin
                     n.ph = P_MODE;
                     n.cnt = 8'(qrd_pkg::MODE_CLOCKS);
                  end
                  P_MODE:
                  begin
                     n.ph = P_DUMMY;
                     n.cnt = 8'(DUMMY_CLOCKS - qrd_pkg::MODE_CLOCKS);
                     n.oe_b = qrd_pkg::IO_OE_OFF;
                  end
                  default:
                  begin
                     n.ph = P_DATA;
                  end
               endcase
               if (r.ph == P_MODE && DUMMY_CLOCKS == qrd_pkg::MODE_CLOCKS)
                  n.ph = P_DATA;
            end
            // Release lines on the low mode nibble when dummy equals mode time
            if (r.ph == P_MODE && r.cnt == 8'h02 && DUMMY_CLOCKS == qrd_pkg::MODE_CLOCKS)
               n.oe_b = qrd_pkg::IO_OE_OFF;
         end
         default: n.st = H_IDLE;
      endcase
   end

   // ==========================================================
   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         r <= '{st: H_IDLE, ph: P_END, cs_b: 1'b1, oe_b: qrd_pkg::IO_OE_OFF, default: '0};
      end
      else
      begin
         r <= n;
      end
   end

   assign lnk.sclk      = r.sclk;
   assign lnk.cs_b      = r.cs_b;
   assign lnk.h_io_o    = r.io;
   assign lnk.h_io_oe_b = r.oe_b;
   assign busy_o        = (r.st != H_IDLE);
   assign data_valid_o  = r.dv;
   assign data_o        = r.data;
endmodule
`default_nettype wire

// ---- qrd_dev.sv ----
// Device end: decodes quad I/O reads, serves data, tracks skip mode.
// Assumes sclk idles low between frames and runs only with cs_b low.
`timescale 1ns/1ps
`default_nettype none
module qrd_dev #(
   parameter int DUMMY_CLOCKS = qrd_pkg::DUMMY_DEFAULT
) (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        four_byte_address_select_i,
   output logic             opcode_skip_read_mode_o,  // Synced to ref_clk_i
   output logic [31:0]      rd_addr_o,                // Current read address, zero after deselect
   qrd_if.dev               lnk
);
   typedef enum {D_FRESH, D_OP, D_ADDR, D_MODE, D_DUMMY, D_DATA, D_IGNORE} dstate_e;
   typedef struct packed {
      dstate_e     st;
      logic [7:0]  cnt;
      logic [7:0]  op;
      logic [31:0] addr;
      logic        wide;
      logic        skip;
      logic [3:0]  mode_hi;
      logic [7:0]  dat;
      logic        half;
   } dst_s;
   typedef struct packed {
      logic [3:0] out;
      logic [3:0] oe_b;
   } dout_s;
   dst_s r, n;
   dout_s o, on;
   logic [7:0] nop;
   logic [2:0] skip_sync_r;

   // ==========================================================
   // Frame decode on rising sclk; frame start forced by cs_b high
   // Phase plan of one frame, in rising sclk edges:
   //   opcode   8 edges on io0, left out while skip mode holds
   //   address  6 or 8 edges, top nibble first
   //   mode     2 edges, only the upper nibble is kept
   //   dummy    DUMMY_CLOCKS less the two mode edges
   //   data     until cs_b returns high
   // The first edge of a frame is handled by D_FRESH, which looks at
   // the skip flag left by the previous frame. Choosing there rather
   // than at deselect keeps the asynchronous frame reset to constants,
   // so no flop loads a data-dependent value through its reset pin.
   // Limitation: four_byte_address_select_i must be steady per frame.
   always_comb
   begin
      n = r;
      nop = {r.op[6:0], lnk.io[0]};
      unique case (r.st)
         D_FRESH:
         begin
            if (r.skip)
            begin
               // No opcode: this edge already carries the top address nibble
               n.wide = four_byte_address_select_i || r.wide;
               n.addr = {28'h000_0000, lnk.io};
               n.cnt  = 8'(n.wide ? qrd_pkg::ADDR4_CLOCKS - 1 : qrd_pkg::ADDR3_CLOCKS - 1);
               n.st   = D_ADDR;
            end
            else
            begin
               // Opcode expected: first of its bits arrives on io0
               n.op  = nop;
               n.cnt = 8'(qrd_pkg::OPCODE_CLOCKS - 1);
               n.st  = D_OP;
            end
         end
         D_OP:
         begin
            n.op = nop;
            n.cnt = r.cnt - 8'h01;
            if (r.cnt == 8'h01)
            begin
               if (nop == qrd_pkg::QUAD_IO_FAST_READ || nop == qrd_pkg::QUAD_IO_FAST_READ_WIDE_ADDRESS)
               begin
                  n.wide = (nop == qrd_pkg::QUAD_IO_FAST_READ_WIDE_ADDRESS) || four_byte_address_select_i;
                  n.st = D_ADDR;
                  n.cnt = 8'(n.wide ? qrd_pkg::ADDR4_CLOCKS : qrd_pkg::ADDR3_CLOCKS);
                  n.addr = '0;
               end
               else
                  n.st = D_IGNORE;
            end
         end
         D_ADDR:
         begin
            n.addr = {r.addr[27:0], lnk.io};
            n.cnt = r.cnt - 8'h01;
            if (r.cnt == 8'h01)
            begin
               n.st = D_MODE;
               n.cnt = 8'(qrd_pkg::MODE_CLOCKS);
            end
         end
         D_MODE:
         begin
            n.cnt = r.cnt - 8'h01;
            if (r.cnt == 8'(qrd_pkg::MODE_CLOCKS))
               n.mode_hi = lnk.io;
            if (r.cnt == 8'h01)
            begin
               n.skip = (r.mode_hi == qrd_pkg::SKIP_KEY_NIBBLE);
               n.cnt = 8'(DUMMY_CLOCKS - qrd_pkg::MODE_CLOCKS);
               n.st = (DUMMY_CLOCKS == qrd_pkg::MODE_CLOCKS) ? D_DATA : D_DUMMY;
            end
         end
         D_DUMMY:
         begin
            n.cnt = r.cnt - 8'h01;
            if (r.cnt == 8'h01)
               n.st = D_DATA;
         end
         D_DATA:
         begin
            n.half = ~r.half;
            if (r.half)
               n.addr = r.addr + 32'h0000_0001;
         end
         default: n.st = D_IGNORE;
      endcase
      // Data byte is derived from the address; stands in for the array
      n.dat = n.addr[7:0] ^ n.addr[15:8];
   end

   // ==========================================================
   // Output launched on falling sclk so host samples on the next rise
   // Drive starts only once the dummy count has run out, so the host
   // has a full dummy span to let go of the lines first.
   // The nibble mux reads registered state only, free of io glitches.
   always_comb
   begin
      on.out = r.half ? r.dat[3:0] : r.dat[7:4];
      on.oe_b = (r.st == D_DATA) ? 4'h0 : qrd_pkg::IO_OE_OFF;
   end

   // Frame boundary: cs_b high resets the sequencer, keeping skip mode
   always_ff @(posedge lnk.sclk or posedge lnk.cs_b or negedge rst_b_i)
   begin
      if (!rst_b_i)
         r <= '{st: D_FRESH, cnt: 8'(qrd_pkg::OPCODE_CLOCKS), skip: qrd_pkg::RST_SKIP_MODE, default: '0};
      else if (lnk.cs_b)
      begin
         // Constants only; skip and wide survive the deselect
         r.st   <= D_FRESH;
         r.cnt  <= 8'h00;
         r.addr <= '0;
         r.half <= 1'b0;
      end
      else
         r <= n;
   end

   always_ff @(negedge lnk.sclk or posedge lnk.cs_b or negedge rst_b_i)
   begin
      if (!rst_b_i)
         o <= '{out: qrd_pkg::RST_NIB, oe_b: qrd_pkg::IO_OE_OFF};
      else if (lnk.cs_b)
         o <= '{out: qrd_pkg::RST_NIB, oe_b: qrd_pkg::IO_OE_OFF};
      else
         o <= on;
   end

   // ==========================================================
   // Skip-mode level to the reference domain; third stage confirms
   // Only a single level crosses, so three flops are enough; the
   // flag changes at most once per frame, far slower than ref_clk_i.
   // The first stage feeds nothing but the second.
   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         skip_sync_r <= 3'h0;
         opcode_skip_read_mode_o <= qrd_pkg::RST_SKIP_MODE;
      end
      else
      begin
         skip_sync_r <= {skip_sync_r[1:0], r.skip};
         if (skip_sync_r[1] == skip_sync_r[2])
            opcode_skip_read_mode_o <= skip_sync_r[2];
      end
   end

   // ==========================================================
   // Link outputs straight from the falling-edge flops
   assign lnk.d_io_o    = o.out;
   assign lnk.d_io_oe_b = o.oe_b;
   assign rd_addr_o     = r.addr;  // Link-domain, read only when idle
endmodule
`default_nettype wire

// ---- qrd_asserts.sv ----
// Checker for the quad read link wires between host and device ends.
// Assumes sclk is derived from ref_clk_i and both ends use six dummies.
`timescale 1ns/1ps
`default_nettype none
module qrd_asserts (
   input wire logic       ref_clk_i,
   input wire logic       rst_b_i,
   input wire logic       sclk,
   input wire logic       cs_b,
   input wire logic [3:0] h_io_oe_b,
   input wire logic [3:0] d_io_o,
   input wire logic [3:0] d_io_oe_b
);
   // ==========================================================
   // Link checks, sampled on the host clock
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);

   // Host floats after the mode byte; device then waits out the dummies
   sequence host_let_go;
      !cs_b && $rose(h_io_oe_b == 4'hF);
   endsequence
   sequence dummy_quiet;
      (d_io_oe_b == 4'hF) [*6] ##[1:4] (d_io_oe_b == 4'h0);
   endsequence

   no_clash_a: assert property ((h_io_oe_b | d_io_oe_b) == 4'hF)
      else $error("both ends drive io");
   dummy_gap_a: assert property (host_let_go |-> dummy_quiet)
      else $error("data start off");
   dev_release_a: assert property (cs_b |-> d_io_oe_b == 4'hF)
      else $error("device drives while deselected");
   host_release_a: assert property (cs_b |-> h_io_oe_b == 4'hF)
      else $error("host drives while deselected");
   sclk_idle_a: assert property (cs_b |-> !sclk)
      else $error("sclk runs outside frame");
   sclk_pulse_a: assert property (!cs_b && sclk |=> !sclk)
      else $error("sclk high too long");
   dev_width_a: assert property (d_io_oe_b == 4'h0 || d_io_oe_b == 4'hF)
      else $error("device drives part of io");
   host_width_a: assert property (h_io_oe_b inside {4'h0, 4'hE, 4'hF})
      else $error("host enable pattern bad");
   // Nibbles are launched on falling sclk only
   data_launch_a: assert property (!cs_b && d_io_oe_b == 4'h0 && $changed(d_io_o) |-> $fell(sclk))
      else $error("data changed off sclk fall");
endmodule
`default_nettype wire

// ---- quad_io_continuous_read_tb.sv ----
// Bench for the quad read link: host and device ends face each other.
// Assumes both ends take DUMMY_CLOCKS and the host makes sclk.
`timescale 1ns/1ps
`default_nettype none
module quad_io_continuous_read_tb;
   typedef struct {logic skip, stay, wide, wop, ext; logic [31:0] addr; logic [15:0] nib;} row_s;
   localparam int DUMMY = 6;
   logic       ref_clk = 1'b0;
   logic       rst_b   = 1'b0;
   logic       start   = 1'b0;
   logic       busy;
   logic       dv;
   logic       skip_mode;
   logic [7:0] data;
   logic [3:0] q[$];
   logic [7:0] dq[$];
   int         errors  = 0;
   int         checks  = 0;
   int         cyc     = 0;
   // Skip, stay, wide, wide opcode, wide select, address, nibbles
   row_s rows[6] = '{'{1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 32'h001234FE, 16'h0006},
                     '{1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 32'h00ABCDEF, 16'h0002},
                     '{1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 32'h0000FF01, 16'h0004},
                     '{1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 32'hC3A55A0F, 16'h0002},
                     '{1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 32'h800000FF, 16'h0004},
                     '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 32'h12345678, 16'h0002}};
   row_s cur = rows[0];

   // ==========================================================
   // Ends and wire checker
   qrd_if qrd_if_inst ();
   qrd_host #(.DUMMY_CLOCKS(DUMMY)) qrd_host_inst (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .start_i(start),
      .addr_i(cur.addr), .wide_i(cur.wide), .wide_op_i(cur.wop), .skip_op_i(cur.skip), .stay_i(cur.stay),
      .nibbles_i(cur.nib), .busy_o(busy), .data_valid_o(dv), .data_o(data), .lnk(qrd_if_inst.host));
   qrd_dev #(.DUMMY_CLOCKS(DUMMY)) qrd_dev_inst (.ref_clk_i(ref_clk), .rst_b_i(rst_b),
      .four_byte_address_select_i(cur.ext), .opcode_skip_read_mode_o(skip_mode), .rd_addr_o(),
      .lnk(qrd_if_inst.dev));
   qrd_asserts qrd_asserts_inst (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .sclk(qrd_if_inst.sclk),
      .cs_b(qrd_if_inst.cs_b), .h_io_oe_b(qrd_if_inst.h_io_oe_b), .d_io_o(qrd_if_inst.d_io_o),
      .d_io_oe_b(qrd_if_inst.d_io_oe_b));

   // ==========================================================
   // Clock, cycle ceiling, capture of wire nibbles and bytes
   always #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      cyc++;
      if (dv === 1'b1) dq.push_back(data);
      if (cyc == 5000)
      begin
         errors++;
         give_verdict();
      end
   end
   // Wire nibbles as the device samples them
   always @(posedge qrd_if_inst.sclk) if (qrd_if_inst.cs_b === 1'b0) q.push_back(qrd_if_inst.io);

   task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   function automatic logic [7:0] byte_of(input logic [31:0] x);
      return x[7:0] ^ x[15:8];
   endfunction

   task automatic give_verdict();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // One read; a second start mid frame must be ignored
   task automatic run(input row_s r, input bit twice);
      int          i;
      int          n;
      logic [31:0] a;
      logic [7:0]  op;
      q.delete();
      dq.delete();
      @(posedge ref_clk) #1;
      cur = r;
      start = 1'b1;
      @(posedge ref_clk) #1;
      start = 1'b0;
      if (twice)
      begin
         repeat (10) @(posedge ref_clk) #1;
         start = 1'b1;
         @(posedge ref_clk) #1;
         start = 1'b0;
      end
      for (i = 0; i < 400 && busy !== 1'b0; i++) @(posedge ref_clk) #1;
      repeat (6) @(posedge ref_clk) #1; // Skip flag crosses three flops
      a = r.wide ? r.addr : {8'h00, r.addr[23:0]};
      n = r.wide ? 8 : 6;
      op = r.wop ? qrd_pkg::QUAD_IO_FAST_READ_WIDE_ADDRESS : qrd_pkg::QUAD_IO_FAST_READ;
      i = r.skip ? 0 : 8;
      cmp(busy, 1'b0);
      for (int b = 0; b < i; b++) cmp(q[b][0], op[7-b]);
      for (int k = 0; k < n; k++) cmp(q[i+k], a[4*(n-1-k) +: 4]);
      cmp(q[i+n], r.stay ? 4'hA : 4'h0);
      cmp(q[i+n+DUMMY], byte_of(a) >> 4);
      cmp(dq.size(), r.nib / 2);
      for (int k = 0; k < r.nib / 2; k++) cmp(dq[k], byte_of(a + k));
      cmp(skip_mode, r.stay);
      $display("test done: addr %h", r.addr);
   endtask

   // ==========================================================
   // Reset, table of reads, refused start, reset mid frame
   initial
   begin
      repeat (5) @(posedge ref_clk);
      #1 rst_b = 1'b1;
      cmp(skip_mode, 1'b0);
      cmp(qrd_if_inst.cs_b, 1'b1);
      foreach (rows[j]) run(rows[j], 1'b0);
      run(rows[0], 1'b1);
      // Reset inside a skip frame must drop skip mode
      cur = rows[1];
      @(posedge ref_clk) #1;
      start = 1'b1;
      @(posedge ref_clk) #1;
      start = 1'b0;
      repeat (20) @(posedge ref_clk) #1;
      rst_b = 1'b0;
      repeat (5) @(posedge ref_clk) #1;
      cmp(qrd_if_inst.d_io_oe_b, 4'hF);
      cmp(skip_mode, 1'b0);
      rst_b = 1'b1;
      $display("test done: reset mid frame");
      run(rows[0], 1'b0);
      give_verdict();
   end
endmodule
`default_nettype wire
